// ==== rtl/cic_pkg.sv ====
// Overview of operation
// - Streaming call takes arguments on start without busy
// - Return data valid in the done cycle
// - Slave mode: start, done, return in registers
// - Always-run: start held at one, no done
// - Stall-free return forces stall to zero
// - Unstable argument travels with its own invocation
// - Stable pointer: only its address is stable
// - Stream and slave memories never stable
// - Globals and pointers share one master port
// - Each modifiable global gets an address conduit
// - Constant globals get no master or conduit
// - During reset busy high, done low
// - Busy stays high through initialisation
package cic_pkg;
  // Data path widths
  localparam int DATA_W = 32;
  localparam int PADDR_W = 8;
  // Default pipeline depth and start-up time in cycles
  localparam int PIPE_DEPTH = 3;
  localparam int INIT_CYCLES = 8;
  // Register byte offsets
  localparam logic [7:0] REG_BUSY = 8'h00;
  localparam logic [7:0] REG_START = 8'h04;
  localparam logic [7:0] REG_IRQ_EN = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RETDATA = 8'h10;
  localparam logic [7:0] REG_ARG = 8'h14;
  localparam logic [7:0] REG_STABLE = 8'h18;
  // Field positions in the status register
  localparam int ST_IRQ_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Call protocol
  typedef enum logic [1:0] {
    MODE_STREAM = 2'b00,
    MODE_SLAVE = 2'b01,
    MODE_ALWAYS = 2'b10
  } cic_mode_t;
  // Argument fetch sequencer
  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_GVAR = 2'b01,
    F_PTR = 2'b10,
    F_ISSUE = 2'b11
  } cic_fetch_t;
  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [PADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } cic_apb_req_t;
  // APB answer
  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } cic_apb_rsp_t;
  // Shared memory master request
  typedef struct packed {
    logic read;
    logic [DATA_W-1:0] addr;
  } cic_mm_req_t;
  // Memory master answer
  typedef struct packed {
    logic accept;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
  } cic_mm_rsp_t;
endpackage

// ==== rtl/cic_invoke_ctrl.sv ====
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns
module cic_invoke_ctrl #(
  parameter cic_pkg::cic_mode_t MODE = cic_pkg::MODE_STREAM,
  parameter bit STALL_FREE = 1'b0,
  parameter bit GVAR_CONST = 1'b0,
  parameter int DEPTH = cic_pkg::PIPE_DEPTH,
  parameter int INIT_CYCLES = cic_pkg::INIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire cic_pkg::cic_apb_req_t apb_req,
  output cic_pkg::cic_apb_rsp_t apb_rsp,
  input wire logic call_start,
  output logic call_busy,
  input wire logic [31:0] call_arg,
  input wire logic [31:0] stable_arg,
  output logic ret_done,
  output logic ret_valid,
  input wire logic ret_stall,
  output logic [31:0] ret_data,
  output logic irq_done,
  input wire logic [31:0] gvar_addr,
  input wire logic [31:0] ptr_addr,
  output cic_pkg::cic_mm_req_t mm_req,
  input wire cic_pkg::cic_mm_rsp_t mm_rsp
);

  // Refuse settings the logic cannot serve
  if (DEPTH < 1 || DEPTH > 16) begin : g_bad_depth
    $error("DEPTH must lie in 1..16");
  end
  if (INIT_CYCLES < 1 || INIT_CYCLES > 255) begin : g_bad_init
    $error("INIT_CYCLES must lie in 1..255");
  end

  // All state of the block
  typedef struct packed {
    logic [7:0] init_cnt; // Start-up countdown
    cic_pkg::cic_fetch_t fst; // Fetch sequencer state
    logic [31:0] arg; // Captured unstable argument
    logic [31:0] acc; // Sum of fetched memory words
    logic mm_rd; // Master read pending
    logic [31:0] mm_addr; // Master read address
    logic [DEPTH-1:0] pv; // Stage valid flags
    logic [DEPTH-1:0][31:0] pd; // Stage data
    logic [1:0] cnt; // Output buffer fill
    logic [1:0][31:0] obuf; // Output buffer slots
    logic start_pend; // Software start waiting
    logic irq_en; // Interrupt enable
    logic irq_st; // Sticky completion status
    logic done_st; // Result ready for software
    logic [31:0] ret_reg; // Return data register
    logic [31:0] s_arg; // Register argument
    logic [31:0] s_stab; // Register stable argument
    logic [31:0] rdata; // APB read data
    logic err; // APB error for this access
  } cic_state_t;

  cic_state_t s_q;
  cic_state_t s_d;

  logic stall_eff; // Stall seen by the return path
  logic busy; // Unable to take a call
  logic go; // Call accepted this cycle
  logic adv; // Pipeline moves this cycle
  logic buf_rdy; // Buffer can take a word
  logic out_rdy; // Consumer takes the head word
  logic pop; // Head word leaves the buffer
  logic push; // Last stage enters the buffer
  logic wr_acc; // APB write takes effect
  logic setup; // APB setup cycle
  logic map_hit; // Address is mapped
  logic [31:0] use_stab; // Stable argument in force
  logic [31:0] use_arg; // Unstable argument source

  // Control terms shared by the sequencer and buffer
  always_comb begin
    // Stall-free return ties stall low
    stall_eff = STALL_FREE ? 1'b0 : ret_stall;
    // Busy through start-up and while a call is fetched
    busy = (s_q.init_cnt != 8'h00) || (s_q.fst != cic_pkg::F_IDLE);
    // Only conduit or register arguments may be stable
    case (MODE)
      cic_pkg::MODE_STREAM: begin
        go = call_start && !busy;
        out_rdy = !stall_eff;
        use_arg = call_arg;
        use_stab = stable_arg;
      end
      cic_pkg::MODE_SLAVE: begin
        go = s_q.start_pend && !busy;
        out_rdy = !s_q.done_st;
        use_arg = s_q.s_arg;
        use_stab = s_q.s_stab;
      end
      default: begin
        // Start is held at one inside the block
        go = !busy;
        out_rdy = !stall_eff;
        use_arg = call_arg;
        use_stab = stable_arg;
      end
    endcase
    buf_rdy = (s_q.cnt != 2'd2);
    adv = !(s_q.pv[DEPTH-1] && !buf_rdy);
    push = adv && s_q.pv[DEPTH-1];
    pop = (s_q.cnt != 2'd0) && out_rdy;
    setup = apb_req.psel && !apb_req.penable;
    wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
    case (apb_req.paddr)
      cic_pkg::REG_BUSY, cic_pkg::REG_START, cic_pkg::REG_IRQ_EN,
      cic_pkg::REG_STATUS, cic_pkg::REG_RETDATA, cic_pkg::REG_ARG,
      cic_pkg::REG_STABLE: begin
        map_hit = 1'b1;
      end
      default: begin
        map_hit = 1'b0;
      end
    endcase
  end

  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    // Count down the start-up time
    if (s_q.init_cnt != 8'h00) begin
      s_d.init_cnt = s_q.init_cnt - 8'h01;
    end
    // Master read is dropped once the port accepts it
    if (s_q.mm_rd && mm_rsp.accept) begin
      s_d.mm_rd = 1'b0;
    end
    // Fetch sequencer: one master port serves global and pointer
    case (s_q.fst)
      cic_pkg::F_IDLE: begin
        if (go) begin
          s_d.arg = use_arg;
          s_d.acc = cic_pkg::RST_WORD;
          s_d.mm_rd = 1'b1;
          if (GVAR_CONST) begin
            // Constant globals need no fetch or address
            s_d.mm_addr = ptr_addr;
            s_d.fst = cic_pkg::F_PTR;
          end else begin
            // Global fetched through its address conduit
            s_d.mm_addr = gvar_addr;
            s_d.fst = cic_pkg::F_GVAR;
          end
        end
      end
      cic_pkg::F_GVAR: begin
        // Pointer read waits for the global read
        if (!s_q.mm_rd && mm_rsp.rvalid) begin
          s_d.acc = s_q.acc + mm_rsp.rdata;
          s_d.mm_addr = ptr_addr;
          s_d.mm_rd = 1'b1;
          s_d.fst = cic_pkg::F_PTR;
        end
      end
      cic_pkg::F_PTR: begin
        if (!s_q.mm_rd && mm_rsp.rvalid) begin
          s_d.acc = s_q.acc + mm_rsp.rdata;
          s_d.fst = cic_pkg::F_ISSUE;
        end
      end
      default: begin
        // Leaves only when stage 0 takes the call
        if (adv) begin
          s_d.fst = cic_pkg::F_IDLE;
        end
      end
    endcase
    // Pipeline: each stage carries its own invocation
    if (adv) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        s_d.pv[i] = s_q.pv[i-1];
        s_d.pd[i] = s_q.pd[i-1];
      end
      s_d.pv[0] = (s_q.fst == cic_pkg::F_ISSUE);
      // Stable argument read at use, never carried
      s_d.pd[0] = s_q.arg + s_q.acc + use_stab;
    end
    // Two-entry output buffer; head stands while stalled
    case ({push, pop})
      2'b10: begin
        s_d.obuf[s_q.cnt[0]] = s_q.pd[DEPTH-1];
        s_d.cnt = s_q.cnt + 2'd1;
      end
      2'b01: begin
        s_d.obuf[0] = s_q.obuf[1];
        s_d.cnt = s_q.cnt - 2'd1;
      end
      2'b11: begin
        if (s_q.cnt == 2'd1) begin
          s_d.obuf[0] = s_q.pd[DEPTH-1];
        end else begin
          s_d.obuf[0] = s_q.obuf[1];
          s_d.obuf[1] = s_q.pd[DEPTH-1];
        end
      end
      default: begin
        s_d.cnt = s_q.cnt;
      end
    endcase
    // Software start consumed by the call
    if (go) begin
      s_d.start_pend = 1'b0;
    end
    // APB writes take effect in the access cycle
    if (wr_acc) begin
      case (apb_req.paddr)
        cic_pkg::REG_START: begin
          if (apb_req.pwdata[0] && MODE == cic_pkg::MODE_SLAVE) begin
            s_d.start_pend = 1'b1;
            s_d.done_st = 1'b0;
          end
        end
        cic_pkg::REG_IRQ_EN: begin
          s_d.irq_en = apb_req.pwdata[0];
        end
        cic_pkg::REG_STATUS: begin
          // Write one to clear the interrupt status
          if (apb_req.pwdata[cic_pkg::ST_IRQ_BIT]) begin
            s_d.irq_st = 1'b0;
          end
        end
        cic_pkg::REG_ARG: begin
          s_d.s_arg = apb_req.pwdata;
        end
        cic_pkg::REG_STABLE: begin
          s_d.s_stab = apb_req.pwdata;
        end
        default: begin
          s_d.err = s_q.err;
        end
      endcase
    end
    // Slave mode: result lands in registers; set beats clear
    if (MODE == cic_pkg::MODE_SLAVE && pop) begin
      s_d.ret_reg = s_q.obuf[0];
      s_d.done_st = 1'b1;
      s_d.irq_st = 1'b1;
    end
    // Read data and error captured in the setup cycle
    if (setup) begin
      s_d.err = !map_hit;
      case (apb_req.paddr)
        cic_pkg::REG_BUSY: begin
          s_d.rdata = {31'h0000_0000, busy};
        end
        cic_pkg::REG_IRQ_EN: begin
          s_d.rdata = {31'h0000_0000, s_q.irq_en};
        end
        cic_pkg::REG_STATUS: begin
          s_d.rdata = {30'h0000_0000, s_q.done_st, s_q.irq_st};
        end
        cic_pkg::REG_RETDATA: begin
          s_d.rdata = s_q.ret_reg;
        end
        cic_pkg::REG_ARG: begin
          s_d.rdata = s_q.s_arg;
        end
        cic_pkg::REG_STABLE: begin
          s_d.rdata = s_q.s_stab;
        end
        default: begin
          s_d.rdata = cic_pkg::RST_WORD;
        end
      endcase
    end
  end

  // State register; reset holds busy high and done low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.init_cnt <= 8'(INIT_CYCLES);
      s_q.fst <= cic_pkg::F_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  always_comb begin
    call_busy = busy;
    ret_valid = (s_q.cnt != 2'd0);
    // Done only in streaming mode, with its data
    ret_done = (MODE == cic_pkg::MODE_STREAM) && ret_valid;
    ret_data = s_q.obuf[0];
    irq_done = (MODE == cic_pkg::MODE_SLAVE) && s_q.irq_st && s_q.irq_en;
    mm_req.read = s_q.mm_rd;
    mm_req.addr = s_q.mm_addr;
    apb_rsp.prdata = s_q.rdata;
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = apb_req.psel && apb_req.penable && s_q.err;
  end

endmodule

// ==== test/cic_invoke_ctrl_asserts.sv ====
`timescale 1ns/1ns
module cic_invoke_ctrl_asserts #(
  parameter int INIT_CYCLES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire cic_pkg::cic_apb_req_t apb_req,
  input wire cic_pkg::cic_apb_rsp_t apb_rsp,
  input wire logic call_start,
  input wire logic call_busy,
  input wire logic ret_done,
  input wire logic ret_valid,
  input wire logic ret_stall,
  input wire logic [31:0] ret_data,
  input wire logic [31:0] gvar_addr,
  input wire cic_pkg::cic_mm_req_t mm_req,
  input wire cic_pkg::cic_mm_rsp_t mm_rsp
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Edges since reset release, saturating
  int unsigned up_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_q <= 0;
    end else if (up_q < INIT_CYCLES) begin
      up_q <= up_q + 1;
    end
  end
  // A call taken by the block
  sequence s_take;
    call_start && !call_busy;
  endsequence
  a_busy_init: assert property (up_q + 1 < INIT_CYCLES |-> call_busy)
    else $error("busy low in start-up");
  a_reset_out: assert property ($rose(presetn) |-> call_busy && !ret_done)
    else $error("reset outputs wrong");
  a_take_busy: assert property (s_take |=> call_busy)
    else $error("busy not raised");
  a_take_fetch: assert property (s_take |-> ##[1:2]
    (mm_req.read && mm_req.addr == gvar_addr)) else $error("no global read");
  a_take_result: assert property (s_take |-> ##[4:60] ret_valid)
    else $error("no result");
  a_done_valid: assert property (!ret_done || ret_valid)
    else $error("done without valid");
  a_stall_hold: assert property (ret_done && ret_stall |=>
    ret_done && $stable(ret_data)) else $error("stalled result moved");
  a_mm_hold: assert property (mm_req.read && !mm_rsp.accept |=>
    mm_req.read && $stable(mm_req.addr)) else $error("read dropped");
  a_bad_addr: assert property (apb_req.psel && apb_req.penable &&
    apb_req.paddr > 8'h18 |-> apb_rsp.pslverr) else $error("no slave error");
endmodule
bind cic_invoke_ctrl cic_invoke_ctrl_asserts #(.INIT_CYCLES(INIT_CYCLES))
  u_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .call_start(call_start), .call_busy(call_busy),
  .ret_done(ret_done), .ret_valid(ret_valid), .ret_stall(ret_stall),
  .ret_data(ret_data), .gvar_addr(gvar_addr), .mm_req(mm_req),
  .mm_rsp(mm_rsp));

// ==== test/cic_mem_model.sv ====
`timescale 1ns/1ns
module cic_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire cic_pkg::cic_mm_req_t mm_req,
  output cic_pkg::cic_mm_rsp_t mm_rsp
);
  logic pend_q;
  logic tick_q;
  logic [31:0] word_q;
  // One read in flight; word is address plus one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'h0;
      tick_q <= 1'h0;
      word_q <= 32'h0;
    end else begin
      pend_q <= mm_rsp.accept;
      tick_q <= ~tick_q;
      if (mm_rsp.accept) begin
        word_q <= mm_req.addr + 32'h1;
      end
    end
  end
  // Slow mode takes reads only every other cycle
  assign mm_rsp.accept = mm_req.read & ~pend_q & (~slow | tick_q);
  assign mm_rsp.rvalid = pend_q;
  // Data outside the answer cycle is scrambled
  assign mm_rsp.rdata = pend_q ? word_q : ~word_q;
endmodule

// ==== test/tb_component_invocation_ctrl.sv ====
`timescale 1ns/1ns
module tb_component_invocation_ctrl;
  logic pclk, presetn, start, busy, done, valid, stall, slow, irq;
  logic done_a, valid_a;
  cic_pkg::cic_mm_req_t mreq_a;
  cic_pkg::cic_mm_rsp_t mrsp_a;
  logic [31:0] arg, stab, data, gaddr, pptr;
  cic_pkg::cic_apb_req_t req;
  cic_pkg::cic_apb_rsp_t rsp;
  cic_pkg::cic_mm_req_t mreq;
  cic_pkg::cic_mm_rsp_t mrsp;
  int n_mismatch = 0, checks = 0, cyc = 0;
  logic [31:0] expq[$];
  cic_invoke_ctrl #(.INIT_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .call_start(start), .call_busy(busy),
    .call_arg(arg), .stable_arg(stab), .ret_done(done), .ret_valid(valid),
    .ret_stall(stall), .ret_data(data), .irq_done(irq), .gvar_addr(gaddr),
    .ptr_addr(pptr), .mm_req(mreq), .mm_rsp(mrsp));
  cic_mem_model mem_u (.pclk(pclk), .presetn(presetn), .slow(slow),
    .mm_req(mreq), .mm_rsp(mrsp));
  // Always-running, stall-free copy; its stall pin is held high
  cic_invoke_ctrl #(.MODE(cic_pkg::MODE_ALWAYS), .STALL_FREE(1'b1),
    .INIT_CYCLES(4)) dut_a (.pclk(pclk), .presetn(presetn),
    .apb_req('0), .apb_rsp(), .call_start(1'b1), .call_busy(),
    .call_arg(arg), .stable_arg(stab), .ret_done(done_a),
    .ret_valid(valid_a), .ret_stall(1'b1), .ret_data(), .irq_done(),
    .gvar_addr(gaddr), .ptr_addr(pptr), .mm_req(mreq_a), .mm_rsp(mrsp_a));
  cic_mem_model mem_a (.pclk(pclk), .presetn(presetn), .slow(slow),
    .mm_req(mreq_a), .mm_rsp(mrsp_a));
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report;
    end
  end
  // Every result leaving unstalled is checked in order
  always @(negedge pclk) begin
    if (presetn && done === 1'h1 && stall === 1'h0) begin
      if (expq.size() == 0) chk("extra", 32'h0, 32'h1);
      else chk("ret_data", expq.pop_front(), data);
    end
  end
  function automatic logic [31:0] res(input logic [31:0] a);
    return a + gaddr + pptr + stab + 32'h2;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    req <= '{1'h1, 1'h0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'h1;
    do @(posedge pclk); while (rsp.pready !== 1'h1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask
  // Start is held, even while busy, until the block takes it
  task automatic call(input logic [31:0] a);
    int n = 0;
    @(posedge pclk);
    start <= 1'h1;
    arg <= a;
    do @(negedge pclk); while (busy !== 1'h0 && ++n < 200);
    @(posedge pclk);
    start <= 1'h0;
    arg <= ~a;
    expq.push_back(res(a));
  endtask
  task automatic drain;
    int n = 0;
    do @(negedge pclk); while (expq.size() != 0 && ++n < 300);
    chk("left", 32'h0, expq.size());
  endtask
  task automatic t_reset(input int hold);
    int n = 0;
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (hold) @(posedge pclk);
    expq.delete();
    @(negedge pclk);
    chk("busy", 32'h1, busy);
    chk("done", 32'h0, done);
    @(posedge pclk);
    presetn <= 1'h1;
    do @(negedge pclk); while (busy !== 1'h0 && ++n < 50);
    chk("init", 32'h1, n >= 4 && n < 50);
  endtask
  // Always-run copy yields results with no start and no done
  task automatic t_always;
    int n = 0;
    do @(negedge pclk); while (valid_a !== 1'h1 && ++n < 100);
    chk("run_valid", 32'h1, valid_a);
    chk("run_done", 32'h0, done_a);
    @(negedge pclk);
    chk("run_free", 32'h0, valid_a);
  endtask
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    apb(1'h1, cic_pkg::REG_ARG, 32'ha5a5_0f0f, q, e);
    apb(1'h0, cic_pkg::REG_ARG, 32'h0, q, e);
    chk("arg_reg", 32'ha5a5_0f0f, q);
    apb(1'h0, cic_pkg::REG_BUSY, 32'h0, q, e);
    chk("busy_reg", 32'h0, q);
    apb(1'h0, 8'h20, 32'h0, q, e);
    chk("slverr", 32'h1, e);
    chk("irq", 32'h0, irq);
  endtask
  task automatic t_stall;
    @(posedge pclk);
    stall <= 1'h1;
    call(32'h0000_0055);
    do @(negedge pclk); while (done !== 1'h1 && cyc < 19000);
    repeat (5) begin
      @(negedge pclk);
      chk("held", expq[0], data);
    end
    @(posedge pclk);
    stall <= 1'h0;
    drain;
  endtask
  initial begin
    {presetn, start, stall, slow} = 4'h0;
    req = '0;
    arg = 32'h0;
    stab = 32'h0000_0100;
    gaddr = 32'h0000_1000;
    pptr = 32'h0000_2000;
    t_reset(20);
    t_always;
    t_regs;
    call(32'h1);
    call(32'hffff_fff0);
    slow <= 1'h1;
    call(32'h0000_0777);
    drain;
    t_stall;
    call(32'h7);
    t_reset(2);
    call(32'h9);
    drain;
    final_report;
  end
endmodule
